// File: bench/adcs_top_test.sv
// self-checking bench for the converter sequencer top level.
// assumes adcs_top with default parameters and a 25 MHz core clock.
`include "adcs_params.svh"

module adcs_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    typedef struct {
        logic [7:0] ctrl;
        logic comp;
        logic [7:0] hi;
        logic [7:0] lo;
    } adcs_row_t;
    logic clk, rst_n, ce, wr, rd, low_power, comp_in;
    logic [7:0] addr, wdata, rdata, rv;
    logic conv_power, conv_tick, sample, auto_zero, converting;
    logic load_result, result_invalid, diff_active, input_path_en;
    logic mux_out_pin_en, sh_from_adc_in_pin;
    logic [9:0] dac_code;
    logic [3:0] pos_channel, neg_channel;
    int errors, cmp_count, n_tick, n_samp, n_zero, n_conv, n_idle, dv;
    // ordinary conversions: control, comparator level, results
    adcs_row_t rows [4] = '{'{8'h05, 1'b1, 8'hff, 8'hc0},
        '{8'h12, 1'b0, 8'h00, 8'h00}, '{8'h2a, 1'b1, 8'hff, 8'hc0},
        '{8'h3f, 1'b0, 8'h00, 8'h00}};

    adcs_top dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .low_power(low_power), .comp_in(comp_in),
        .conv_power(conv_power), .conv_tick(conv_tick), .sample(sample),
        .auto_zero(auto_zero), .converting(converting),
        .load_result(load_result), .dac_code(dac_code),
        .result_invalid(result_invalid), .pos_channel(pos_channel),
        .neg_channel(neg_channel), .diff_active(diff_active),
        .input_path_en(input_path_en), .mux_out_pin_en(mux_out_pin_en),
        .sh_from_adc_in_pin(sh_from_adc_in_pin));

    // 40 ns core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // phase counters, sampled mid-cycle where outputs are settled
    always @(negedge clk) begin
        if (conv_power === 1'b1) begin
            // only ticks inside a phase; the opening tick starts sampling
            n_tick += int'(conv_tick && (sample || auto_zero
                || converting || load_result));
            n_samp += int'(sample);
            n_zero += int'(auto_zero);
            n_conv += int'(converting);
        end else if (conv_tick === 1'b1) begin
            n_idle++;
        end
    end

    // ------------------------------------------------------------
    // compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time,
                     what, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp, input string what);
        cmp_count++;
        if (got != exp) begin
            errors++;
            $display("wrong value at %0t: %s got %0d want %0d", $time,
                     what, got, exp);
        end
    endtask
    // one write strobe, called just after a rising edge
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // one read strobe; data taken in the following cycle only
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    // poll the busy bit under a bounded count
    task automatic wait_done(input logic [7:0] c);
        rv = 8'h80;
        for (int i = 0; i < 200; i++) begin
            if (rv[7] !== 1'b0) rreg(`ADCS_OFF_CTRL, rv);
        end
        chk(rv, c, "control after done");
    endtask
    task automatic results(input logic [7:0] hi, input logic [7:0] lo);
        rreg(`ADCS_OFF_RES_UPPER, rv);
        chk(rv, hi, "upper result");
        rreg(`ADCS_OFF_RES_LOWER, rv);
        chk(rv, lo, "lower result");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: all tests need well under 5000 cycles
    initial begin
        #(40 * 20000);
        errors++;
        finish_test;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, wr, rd, low_power, comp_in, addr, wdata} = '0;
        ce = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset value and an unmapped address
        rreg(`ADCS_OFF_CTRL, rv);
        chk(rv, `ADCS_CTRL_RESET, "control reset");
        rreg(8'h07, rv);
        chk(rv, 8'h00, "unmapped read");
        $display("test reset done");
        // table of ordinary conversions
        foreach (rows[i]) begin
            dv = rows[i].ctrl[5] ? 16 : 1; // prescale per row
            comp_in <= rows[i].comp;
            {n_tick, n_samp, n_zero, n_conv} = '0;
            wreg(`ADCS_OFF_CTRL, rows[i].ctrl | 8'h80);
            wait_done(rows[i].ctrl);
            chk_n(n_tick, 15, "converter ticks");
            chk_n(n_samp, 3 * dv, "sample cycles");
            chk_n(n_zero, dv, "auto-zero cycles");
            chk_n(n_conv, 10 * dv, "convert cycles");
            chk({pos_channel, neg_channel}, {rows[i].ctrl[3:0],
                rows[i].ctrl[3:1], ~rows[i].ctrl[0]}, "channels");
            chk(8'(diff_active), 8'(rows[i].ctrl[4]), "mode");
            results(rows[i].hi, rows[i].lo);
            chk(dac_code[9:2], rows[i].hi, "final dac code");
        end
        $display("test table done");
        // results are writable, lower keeps only its top two bits
        wreg(`ADCS_OFF_RES_UPPER, 8'h5a);
        wreg(`ADCS_OFF_RES_LOWER, 8'hff);
        results(8'h5a, 8'hc0);
        // writes while busy, back-to-back stop and start, abort
        wreg(`ADCS_OFF_CTRL, 8'ha3);
        wreg(`ADCS_OFF_CTRL, 8'h94);
        rreg(`ADCS_OFF_CTRL, rv);
        chk(rv, 8'ha3, "settings locked while busy");
        addr <= `ADCS_OFF_CTRL;
        wdata <= 8'h23;
        wr <= 1'b1;
        @(posedge clk);
        wdata <= 8'h86;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        rreg(`ADCS_OFF_CTRL, rv);
        chk(rv, 8'h86, "restart with new settings");
        wreg(`ADCS_OFF_CTRL, 8'h06);
        results(8'h5a, 8'hc0);
        $display("test abort done");
        // mux output routing with busy clear, then a conversion
        n_idle = 0;
        wreg(`ADCS_OFF_CTRL, 8'h41);
        repeat (4) @(posedge clk);
        chk({input_path_en, mux_out_pin_en, sh_from_adc_in_pin, 1'b0,
            pos_channel}, 8'he1, "mux routing idle");
        chk_n(n_idle, 0, "idle converter ticks");
        comp_in <= 1'b0;
        wreg(`ADCS_OFF_CTRL, 8'hc1);
        wait_done(8'h41);
        chk({input_path_en, mux_out_pin_en, sh_from_adc_in_pin, 1'b0,
            pos_channel}, 8'he1, "mux routing after");
        results(8'h00, 8'h00);
        $display("test mux done");
        // low power in mid-conversion restarts from the beginning
        comp_in <= 1'b1;
        wreg(`ADCS_OFF_CTRL, 8'ha0);
        repeat (60) @(posedge clk);
        low_power <= 1'b1;
        repeat (4) @(posedge clk);
        chk({conv_power, result_invalid}, 8'h01, "low power");
        low_power <= 1'b0;
        {n_tick, n_samp} = '0;
        wait_done(8'h20);
        chk_n(n_tick, 15, "ticks after wake");
        chk_n(n_samp, 48, "sample after wake");
        results(8'hff, 8'hc0);
        $display("test low power done");
        finish_test;
    end
endmodule

// File: common/adcs_params.svh
// constants for the converter sequencer: offsets, field positions,
// reset values and phase lengths in converter clocks.
// assumes an 8-bit register port with byte-wide registers.
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADCS_OFF_CTRL 8'h00
`define ADCS_OFF_RES_UPPER 8'h01
`define ADCS_OFF_RES_LOWER 8'h02

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ADCS_CH_LSB 0
`define ADCS_CH_MSB 3
`define ADCS_DIFF_BIT 4
`define ADCS_PSC_BIT 5
`define ADCS_MUX_BIT 6
`define ADCS_BUSY_BIT 7
`define ADCS_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// lower result register: two result bits at the top
// ----------------------------------------------------------------
`define ADCS_RES_LOWER_LSB 6

// ----------------------------------------------------------------
// phase lengths in converter clocks, and slow prescale ratio
// ----------------------------------------------------------------
`define ADCS_SAMPLE_TICKS 4'd3
`define ADCS_AZERO_TICKS 4'd1
`define ADCS_CONV_TICKS 4'd10
`define ADCS_LOAD_TICKS 4'd1
`define ADCS_SLOW_DIV 16

`endif

// File: common/adcs_pkg.sv
// types shared by the converter sequencer files.
// assumes nothing beyond a SystemVerilog compiler.
package adcs_pkg;

    // ------------------------------------------------------------
    // conversion sequence phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_SAMPLE,
        ST_AZERO,
        ST_CONV,
        ST_LOAD
    } adcs_state_t;

endpackage

// File: verilog/adcs_prescaler.sv
// converter clock prescaler: emits one-cycle ticks at core rate or at
// core rate divided by DIV; cleared, with no ticks, while run is low.
// assumes clk is the core clock and ce freezes all state.
`include "adcs_params.svh"

module adcs_prescaler #(
    parameter int DIV = `ADCS_SLOW_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic run,
    input wire logic div_slow,
    // converter clock tick
    output logic tick
);

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt; // core cycles since last slow tick

    // ------------------------------------------------------------
    // divider: cleared while stopped so power and phase restart clean
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                // stopped: no converter clock
                cnt <= '0;
                tick <= 1'b0;
            end else begin
                cnt <= cnt + 1'b1;
                // divide by one or by DIV
                tick <= !div_slow || (cnt == CW'(DIV - 1));
            end
        end
    end

    a_slow_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(tick) && div_slow |=> !tick)
        else $error("slow prescale tick lasted more than one cycle");

endmodule

// File: verilog/adcs_top.sv
// converter sequencer: control and result registers behind a plain
// register port, a gated prescaler and the fifteen-tick sample,
// auto-zero, successive-approximation and load sequence.
// assumes synchronous inputs, one core clock and an external
// comparator answering the dac code within one converter clock.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`include "adcs_params.svh"

module adcs_top #(
    parameter int RES_W = 10,
    parameter int DIV = `ADCS_SLOW_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // device power state (halt or idle)
    input wire logic low_power,
    // converter analog core
    input wire logic comp_in,
    output logic conv_power,
    output logic conv_tick,
    output logic sample,
    output logic auto_zero,
    output logic converting,
    output logic load_result,
    output logic [RES_W-1:0] dac_code,
    output logic result_invalid,
    // input multiplexor routing
    output logic [3:0] pos_channel,
    output logic [3:0] neg_channel,
    output logic diff_active,
    output logic input_path_en,
    output logic mux_out_pin_en,
    output logic sh_from_adc_in_pin
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] channel_select; // analog input choice
    logic diff_mode_sel; // 1 selects differential
    logic clock_prescale_sel; // 1 selects slow prescale
    logic mux_out_enable; // route mux to external pins
    logic conversion_busy; // conversion running
    logic [7:0] conversion_result_upper; // result bits 9:2
    logic [1:0] conversion_result_lower; // result bits 1:0
    adcs_pkg::adcs_state_t state; // current phase
    adcs_pkg::adcs_state_t next_state;
    logic [3:0] step; // ticks spent in phase
    logic [3:0] next_step;
    logic next_busy;
    logic [3:0] bit_idx; // result bit under trial

    // ------------------------------------------------------------
    // decodes
    // ------------------------------------------------------------
    logic ctrl_wr; // write to control register
    logic abort; // software clears busy
    logic start; // software sets busy from idle or at end
    logic done; // load tick completes conversion
    logic restart; // low power drops a running conversion
    logic run; // prescaler enable

    // one-hot bit mask for a result bit position
    function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] pos);
        bit_mask = RES_W'(1) << pos;
    endfunction

    assign ctrl_wr = ce && wr && (addr == `ADCS_OFF_CTRL);
    // busy clears act even mid-conversion; sets only from idle or at end
    assign abort = ctrl_wr && !wdata[`ADCS_BUSY_BIT];
    assign done = (state == adcs_pkg::ST_LOAD) && conv_tick
        && !low_power;
    // a set in the completing cycle wins over the hardware clear
    assign start = ctrl_wr && wdata[`ADCS_BUSY_BIT]
        && (!conversion_busy || done);
    assign restart = low_power && conversion_busy;
    assign run = conversion_busy && !low_power;
    assign bit_idx = 4'(RES_W - 1) - step;

    // ------------------------------------------------------------
    // converter clock prescaler
    // ------------------------------------------------------------
    adcs_prescaler #(
        .DIV(DIV)
    ) u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(run),
        .div_slow(clock_prescale_sel),
        .tick(conv_tick)
    );

    // ------------------------------------------------------------
    // control fields: locked while a conversion runs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_select <= 4'h0;
            diff_mode_sel <= 1'b0;
            clock_prescale_sel <= 1'b0;
            mux_out_enable <= 1'b0;
        end else if (ctrl_wr && !conversion_busy) begin
            // settings and busy in one write
            channel_select <= wdata[`ADCS_CH_MSB:`ADCS_CH_LSB];
            diff_mode_sel <= wdata[`ADCS_DIFF_BIT];
            clock_prescale_sel <= wdata[`ADCS_PSC_BIT];
            mux_out_enable <= wdata[`ADCS_MUX_BIT];
        end
    end

    // ------------------------------------------------------------
    // busy flag
    // ------------------------------------------------------------
    always_comb begin
        next_busy = conversion_busy;
        if (abort) begin
            next_busy = 1'b0;
        end else if (start) begin
            next_busy = 1'b1;
        end else if (done) begin
            next_busy = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_busy <= 1'b0;
        end else if (ce) begin
            conversion_busy <= next_busy;
        end
    end

    // ------------------------------------------------------------
    // sequence: wait, 3 sample, 1 auto-zero, 10 bits, 1 load
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_step = step;
        if (abort) begin
            next_state = adcs_pkg::ST_IDLE;
            next_step = 4'h0;
        end else if (start || restart) begin
            // restart from the top after wake-up
            next_state = adcs_pkg::ST_WAIT;
            next_step = 4'h0;
        end else if (conv_tick) begin
            next_step = step + 4'h1;
            unique case (state)
                adcs_pkg::ST_IDLE: begin
                    next_step = 4'h0;
                end
                adcs_pkg::ST_WAIT: begin
                    // first converter edge opens sampling
                    next_state = adcs_pkg::ST_SAMPLE;
                    next_step = 4'h0;
                end
                adcs_pkg::ST_SAMPLE: begin
                    if (step == `ADCS_SAMPLE_TICKS - 4'h1) begin
                        next_state = adcs_pkg::ST_AZERO;
                        next_step = 4'h0;
                    end
                end
                adcs_pkg::ST_AZERO: begin
                    if (step == `ADCS_AZERO_TICKS - 4'h1) begin
                        next_state = adcs_pkg::ST_CONV;
                        next_step = 4'h0;
                    end
                end
                adcs_pkg::ST_CONV: begin
                    if (step == `ADCS_CONV_TICKS - 4'h1) begin
                        next_state = adcs_pkg::ST_LOAD;
                        next_step = 4'h0;
                    end
                end
                adcs_pkg::ST_LOAD: begin
                    if (step == `ADCS_LOAD_TICKS - 4'h1) begin
                        next_state = adcs_pkg::ST_IDLE;
                        next_step = 4'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= adcs_pkg::ST_IDLE;
            step <= 4'h0;
        end else if (ce) begin
            state <= next_state;
            step <= next_step;
        end
    end

    // ------------------------------------------------------------
    // phase strobes and converter power, registered from next state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample <= 1'b0;
            auto_zero <= 1'b0;
            converting <= 1'b0;
            load_result <= 1'b0;
            conv_power <= 1'b0;
        end else if (ce) begin
            sample <= next_state == adcs_pkg::ST_SAMPLE;
            auto_zero <= next_state == adcs_pkg::ST_AZERO;
            converting <= next_state == adcs_pkg::ST_CONV;
            load_result <= next_state == adcs_pkg::ST_LOAD;
            // powered only while busy and awake
            conv_power <= next_busy && !low_power;
        end
    end

    // ------------------------------------------------------------
    // successive approximation register driving the dac
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_code <= '0;
        end else if (ce && conv_tick && !abort && !start && !restart) begin
            if (state == adcs_pkg::ST_AZERO) begin
                // first trial: top bit only
                dac_code <= bit_mask(4'(RES_W - 1));
            end else if (state == adcs_pkg::ST_CONV) begin
                // keep or drop the trial bit, then try the next
                if (step == `ADCS_CONV_TICKS - 4'h1) begin
                    dac_code <= comp_in ? dac_code
                        : dac_code & ~bit_mask(bit_idx);
                end else begin
                    dac_code <= (comp_in ? dac_code
                        : dac_code & ~bit_mask(bit_idx))
                        | bit_mask(bit_idx - 4'h1);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // result registers: no reset, undefined until first load or write
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (ce) begin
            if (done && !abort) begin
                // split load on completion, never on abort
                conversion_result_upper <= dac_code[RES_W-1:2];
                conversion_result_lower <= dac_code[1:0];
            end else if (wr && addr == `ADCS_OFF_RES_UPPER) begin
                conversion_result_upper <= wdata;
            end else if (wr && addr == `ADCS_OFF_RES_LOWER) begin
                conversion_result_lower <= wdata[7:`ADCS_RES_LOWER_LSB];
            end
        end
    end

    // ------------------------------------------------------------
    // invalid flag: a conversion cut by low power; set beats clear
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_invalid <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                result_invalid <= 1'b1;
            end else if (start) begin
                result_invalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // multiplexor routing; input path enabled whenever busy or mux output is on
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_channel <= 4'h0;
            neg_channel <= 4'h0;
            diff_active <= 1'b0;
            input_path_en <= 1'b0;
            mux_out_pin_en <= 1'b0;
            sh_from_adc_in_pin <= 1'b0;
        end else if (ce) begin
            pos_channel <= channel_select;
            // partner of the pair is the other member of even/odd
            neg_channel <= {channel_select[3:1], ~channel_select[0]};
            diff_active <= diff_mode_sel;
            input_path_en <= next_busy || mux_out_enable;
            mux_out_pin_en <= mux_out_enable;
            sh_from_adc_in_pin <= mux_out_enable;
        end
    end

    // ------------------------------------------------------------
    // register read port: data in the cycle after the strobe only
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= 8'h00;
            if (rd) begin
                unique case (addr)
                    `ADCS_OFF_CTRL: begin
                        rdata <= {conversion_busy, mux_out_enable,
                            clock_prescale_sel, diff_mode_sel,
                            channel_select};
                    end
                    `ADCS_OFF_RES_UPPER: begin
                        rdata <= conversion_result_upper;
                    end
                    `ADCS_OFF_RES_LOWER: begin
                        // low six bits read zero
                        rdata <= {conversion_result_lower, 6'h00};
                    end
                    default: begin
                        rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ctrl_locked: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr && conversion_busy |=> $stable(channel_select)
            && $stable(diff_mode_sel) && $stable(clock_prescale_sel))
        else $error("control field changed while busy");

    a_clock_stopped: assert property (@(posedge clk) disable iff (!rst_n)
        !conversion_busy ##1 !conversion_busy |-> !conv_tick)
        else $error("converter tick while idle");

    a_done_clears: assert property (@(posedge clk) disable iff (!rst_n)
        ce && done && !start && !abort |=> !conversion_busy && !conv_power)
        else $error("busy or power not dropped at completion");

    a_result_split: assert property (@(posedge clk) disable iff (!rst_n)
        ce && done && !abort
        |=> conversion_result_upper == $past(dac_code[9:2])
            && conversion_result_lower == $past(dac_code[1:0]))
        else $error("result not split correctly");

    a_abort_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        ce && abort && conversion_busy
        |=> $stable(conversion_result_upper)
            && $stable(conversion_result_lower))
        else $error("aborted conversion touched results");

    a_sample_start: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state == adcs_pkg::ST_WAIT && conv_tick && !abort && !restart
        && !start |=> sample && step == 4'h0)
        else $error("sampling did not open on first tick");

    a_mux_route: assert property (@(posedge clk) disable iff (!rst_n)
        ce && mux_out_enable |=> input_path_en && mux_out_pin_en
            && sh_from_adc_in_pin)
        else $error("mux output routing dropped");

    a_lp_restart: assert property (@(posedge clk) disable iff (!rst_n)
        ce && restart && !abort |=> state == adcs_pkg::ST_WAIT
            && !conv_power && result_invalid)
        else $error("low power did not restart conversion");

endmodule
